// *** design/ptpt_channel.sv ***
// One compare channel with double-buffered compare value
`timescale 1ns/1ps
module ptpt_channel
    import ptpt_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic [TW-1:0] time_now,
    input  wire logic          run,
    input  wire ptpt_chcfg_t   cfg,
    input  wire logic          cmp_wr,
    input  wire logic [TW-1:0] cmp_wdata,
    output logic      [TW-1:0] cmp_active,
    output logic               event_pulse
);
    logic [TW-1:0] active_reg;
    logic [TW-1:0] buffer_reg;
    logic          evt_reg;
    wire           sw_mode = (cfg.mode == MODE_OC_SW);
    wire           hit     = run && sw_mode && (time_now == active_reg);

    always_ff @(posedge clock) begin
        if (rst) begin
            active_reg <= ZERO_WORD;
            buffer_reg <= ZERO_WORD;
            evt_reg    <= 1'b0;
        end else begin
            if (cmp_wr) begin
                buffer_reg <= cmp_wdata;
                active_reg <= buffer_reg;
            end else if (hit) begin
                active_reg <= buffer_reg;
            end
            evt_reg <= hit;
        end
    end

    assign cmp_active  = active_reg;
    assign event_pulse = evt_reg;
endmodule : ptpt_channel

// *** design/ptpt_counter.sv ***
// Time counter with increment and period wrap
`timescale 1ns/1ps
module ptpt_counter
    import ptpt_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic          run,
    input  wire logic          per_en,
    input  wire logic [TW-1:0] period,
    input  wire logic [TW-1:0] inc,
    input  wire logic          load,
    input  wire logic [TW-1:0] load_val,
    output logic      [TW-1:0] time_now,
    output logic               wrap_pulse
);
    logic [TW-1:0] time_reg;
    logic [TW-1:0] time_next;
    logic          wrap_reg;
    wire           at_period = run && (time_reg >= period);
    wire  [TW-1:0] stepped   = time_reg + inc;

    assign time_next = load ? load_val :
                       !run ? time_reg :
                       (at_period && per_en) ? ZERO_WORD : stepped;

    always_ff @(posedge clock) begin
        if (rst) begin
            time_reg <= ZERO_WORD;
            wrap_reg <= 1'b0;
        end else begin
            time_reg <= time_next;
            wrap_reg <= at_period && !load;
        end
    end

    assign time_now   = time_reg;
    assign wrap_pulse = wrap_reg;
endmodule : ptpt_counter

// *** design/ptpt_pkg.sv ***
// Package for the precision-time timer: offsets, fields, reset values, types
package ptpt_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int NUM_CH    = 4;
    localparam int TW        = 32;
    localparam int AW        = 8;

    // ************************************************************
    // Register offsets (byte addresses)
    // ************************************************************
    localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
    localparam logic [AW-1:0] OFS_TIME     = 8'h04;
    localparam logic [AW-1:0] OFS_PERIOD   = 8'h08;
    localparam logic [AW-1:0] OFS_INC      = 8'h0C;
    localparam logic [AW-1:0] OFS_GSTAT    = 8'h10;
    localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h18;
    localparam logic [AW-1:0] OFS_CH_BASE  = 8'h20;
    localparam logic [AW-1:0] OFS_CH_CSR   = 8'h00;
    localparam logic [AW-1:0] OFS_CH_CMP   = 8'h04;
    localparam int            CH_STRIDE_LG = 3;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_EN       = 0;
    localparam int CTRL_PERIODIC_EVENT_ENABLE    = 1;
    localparam int CSR_FLAG      = 7;
    localparam int CSR_IE        = 6;
    localparam int CSR_MODE_LSB  = 2;
    localparam int IRQ_TSTAMP    = 0;
    localparam int IRQ_WRAP      = 1;
    localparam int IRQ_CH_LSB    = 2;
    localparam int IRQW          = IRQ_CH_LSB + NUM_CH;

    // ************************************************************
    // Encodings and reset values
    // ************************************************************
    localparam logic [3:0]    MODE_OC_SW   = 4'h4;
    localparam logic [3:0]    MODE_OFF     = 4'h0;
    localparam logic [TW-1:0] PERIOD_RST   = 32'hFFFF_FFFF;
    localparam logic [TW-1:0] INC_RST      = 32'h0000_0000;
    localparam logic [TW-1:0] ZERO_WORD    = 32'h0000_0000;
    localparam logic [7:0]    INC_W_RST    = 8'h00;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [TW-1:0] wdata;
        logic          wr;
        logic          rd;
    } ptpt_bus_t;

    typedef struct packed {
        logic          ie;
        logic [3:0]    mode;
    } ptpt_chcfg_t;

endpackage : ptpt_pkg

// *** design/ptpt_timer.sv ***
// Precision-time timer top: registers, counter, compare channels, interrupts
// Notes on behaviour
// - Timer overflow condition rises whenever running counter is at or above period value.
// - Overflow interrupt never reaches the timer interrupt line.
// - Transmit stamp ready interrupt drives the misc line, not timer line.
// - Mode 0100 is software-only output compare, no pin driven.
// - Per-channel enable lets a compare event request timer interrupt.
// - Compare value double buffered; software writes it twice during setup.
// - Control holds periodic enable and counter run enable bits.
// - Channel events on timer line; software reloads compare each event.
// - Channel flag and global channel bit stay set until cleared.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module ptpt_timer
    import ptpt_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          rst,
    input  wire logic [AW-1:0] addr,
    input  wire logic [TW-1:0] wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic      [TW-1:0] rdata,
    input  wire logic          tx_stamp_event,
    output logic               timer_irq,
    output logic               misc_irq,
    output logic               irq
);
    // ************************************************************
    // Registers
    // ************************************************************
    logic [1:0]          ctrl_reg;
    logic [TW-1:0]       time_period_value;
    logic [TW-1:0]       time_increment_reg;
    logic [NUM_CH-1:0]   global_channel_status;
    logic [NUM_CH-1:0]   channel_event_flag;
    logic [NUM_CH-1:0]   channel_irq_enable;
    logic [3:0]          channel_mode_select [NUM_CH];
    logic [IRQW-1:0]     irq_stat_reg;
    logic [IRQW-1:0]     irq_mask_reg;
    logic [TW-1:0]       rdata_reg;
    logic                timer_irq_reg;
    logic                misc_irq_reg;
    logic                irq_reg;

    logic [TW-1:0]       time_now;
    logic                wrap_pulse;
    logic [NUM_CH-1:0]   ch_event;
    logic [TW-1:0]       ch_cmp [NUM_CH];

    ptpt_bus_t bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic logic hit_ofs(input logic [AW-1:0] a, input logic [AW-1:0] o);
        hit_ofs = (a == o);
    endfunction : hit_ofs

    wire           in_ch    = bus.addr >= OFS_CH_BASE;
    wire  [AW-1:0] ch_rel   = bus.addr - OFS_CH_BASE;
    wire  [AW-1:0] ch_sub   = ch_rel & 8'h07;
    wire  [AW-1:0] ch_idx_w = ch_rel >> CH_STRIDE_LG;
    wire           ch_ok    = in_ch && (ch_idx_w < AW'(NUM_CH));
    wire  [1:0]    ch_idx   = ch_idx_w[1:0];

    // One decode per register, shared by the write and the read path
    wire hit_ctrl   = hit_ofs(bus.addr, OFS_CTRL);
    wire hit_time   = hit_ofs(bus.addr, OFS_TIME);
    wire hit_period = hit_ofs(bus.addr, OFS_PERIOD);
    wire hit_inc    = hit_ofs(bus.addr, OFS_INC);
    wire hit_gstat  = hit_ofs(bus.addr, OFS_GSTAT);
    wire hit_istat  = hit_ofs(bus.addr, OFS_IRQ_STAT);
    wire hit_imask  = hit_ofs(bus.addr, OFS_IRQ_MASK);
    wire hit_csr    = ch_ok && hit_ofs(ch_sub, OFS_CH_CSR);
    wire hit_cmp    = ch_ok && hit_ofs(ch_sub, OFS_CH_CMP);

    wire w_ctrl   = bus.wr && hit_ctrl;
    wire w_time   = bus.wr && hit_time;
    wire w_period = bus.wr && hit_period;
    wire w_inc    = bus.wr && hit_inc;
    wire w_gstat  = bus.wr && hit_gstat;
    wire w_istat  = bus.wr && hit_istat;
    wire w_imask  = bus.wr && hit_imask;
    wire w_csr    = bus.wr && hit_csr;
    wire w_cmp    = bus.wr && hit_cmp;

    wire run    = ctrl_reg[CTRL_EN];
    wire per_en = ctrl_reg[CTRL_PERIODIC_EVENT_ENABLE];

    ptpt_counter u_counter (
        .clock      (clock),
        .rst        (rst),
        .run        (run),
        .per_en     (per_en),
        .period     (time_period_value),
        .inc        (time_increment_reg),
        .load       (w_time),
        .load_val   (bus.wdata),
        .time_now   (time_now),
        .wrap_pulse (wrap_pulse)
    );

    // ************************************************************
    // Compare channels
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            wire ptpt_chcfg_t cfg = '{ie: channel_irq_enable[g], mode: channel_mode_select[g]};
            wire              sel = (ch_idx == 2'(g));
            ptpt_channel u_ch (
                .clock       (clock),
                .rst         (rst),
                .time_now    (time_now),
                .run         (run),
                .cfg         (cfg),
                .cmp_wr      (w_cmp && sel),
                .cmp_wdata   (bus.wdata),
                .cmp_active  (ch_cmp[g]),
                .event_pulse (ch_event[g])
            );

            wire       csr_w      = w_csr && sel;
            wire       flag_clr   = csr_w && bus.wdata[CSR_FLAG];
            wire       gstat_clr  = w_gstat && bus.wdata[g];
            // sticky flags, set wins over clear
            wire       flag_next  = ch_event[g] || (channel_event_flag[g] && !flag_clr);
            wire       gstat_next = ch_event[g] || (global_channel_status[g] && !gstat_clr);
            wire [3:0] mode_next  = csr_w ? bus.wdata[CSR_MODE_LSB +: 4] : channel_mode_select[g];
            wire       ie_next    = csr_w ? bus.wdata[CSR_IE] : channel_irq_enable[g];

            always_ff @(posedge clock) begin
                if (rst) begin
                    channel_mode_select[g]   <= MODE_OFF;
                    channel_irq_enable[g]    <= 1'b0;
                    channel_event_flag[g]    <= 1'b0;
                    global_channel_status[g] <= 1'b0;
                end else begin
                    channel_mode_select[g]   <= mode_next;
                    channel_irq_enable[g]    <= ie_next;
                    channel_event_flag[g]    <= flag_next;
                    global_channel_status[g] <= gstat_next;
                end
            end
        end
    endgenerate

    // ************************************************************
    // Interrupt status
    // ************************************************************
    wire [IRQW-1:0] irq_set = {ch_event, wrap_pulse, tx_stamp_event};
    wire [IRQW-1:0] irq_clr = w_istat ? bus.wdata[IRQW-1:0] : '0;
    wire [IRQW-1:0] irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);
    wire [IRQW-1:0] pending = irq_stat_next & irq_mask_reg;

    wire ch_req = |(global_channel_status & channel_irq_enable);
    // wrap interrupt left unconnected to timer line
    wire timer_next = ch_req;
    // tx stamp goes on misc line
    wire misc_next  = pending[IRQ_TSTAMP];

    // ************************************************************
    // Register next values
    // ************************************************************
    // Plain write-over registers except status and irq; a write takes effect on the next edge
    logic [1:0]          ctrl_next;
    logic [TW-1:0]       period_next;
    logic [TW-1:0]       inc_next;
    logic [IRQW-1:0]     mask_next;
    logic [IRQW-1:0]     stat_next;
    logic                irq_next;

    assign ctrl_next   = w_ctrl   ? bus.wdata[1:0]      : ctrl_reg;
    assign period_next = w_period ? bus.wdata           : time_period_value;
    assign inc_next    = w_inc    ? bus.wdata           : time_increment_reg;
    assign mask_next   = w_imask  ? bus.wdata[IRQW-1:0] : irq_mask_reg;
    // Set is ORed in last, so an event in the clearing cycle survives
    assign stat_next   = irq_stat_next;
    assign irq_next    = |pending;

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_reg           <= 2'b00;
            time_period_value  <= PERIOD_RST;
            time_increment_reg <= INC_RST;
            irq_mask_reg       <= '0;
        end else begin
            ctrl_reg           <= ctrl_next;
            time_period_value  <= period_next;
            time_increment_reg <= inc_next;
            irq_mask_reg       <= mask_next;
        end
    end

    // ************************************************************
    // Interrupt outputs
    // ************************************************************
    // Registered so the interrupt pins never glitch on a decode change
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_stat_reg  <= '0;
            timer_irq_reg <= 1'b0;
            misc_irq_reg  <= 1'b0;
            irq_reg       <= 1'b0;
        end else begin
            irq_stat_reg  <= stat_next;
            timer_irq_reg <= timer_next;
            misc_irq_reg  <= misc_next;
            irq_reg       <= irq_next;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    wire [TW-1:0] ch_csr_rd = TW'({channel_event_flag[ch_idx], channel_irq_enable[ch_idx],
                                   channel_mode_select[ch_idx], 2'b00});
    // Narrow registers are zero-extended to the bus width
    wire [TW-1:0] rd_ctrl   = TW'(ctrl_reg);
    wire [TW-1:0] rd_gstat  = TW'(global_channel_status);
    wire [TW-1:0] rd_istat  = TW'(irq_stat_reg);
    wire [TW-1:0] rd_imask  = TW'(irq_mask_reg);
    // Compare reads show the active stage, not the buffered one
    wire [TW-1:0] rd_ch_cmp = ch_cmp[ch_idx];

    wire [TW-1:0] rd_mux =
        hit_ctrl   ? rd_ctrl :
        hit_time   ? time_now :
        hit_period ? time_period_value :
        hit_inc    ? time_increment_reg :
        hit_gstat  ? rd_gstat :
        hit_istat  ? rd_istat :
        hit_imask  ? rd_imask :
        hit_csr    ? ch_csr_rd :
        hit_cmp    ? rd_ch_cmp : ZERO_WORD;

    // Unmapped reads return zero; data stand only in the cycle after rd
    wire [TW-1:0] rdata_next = bus.rd ? rd_mux : ZERO_WORD;

    always_ff @(posedge clock) begin
        if (rst)
            rdata_reg <= ZERO_WORD;
        else
            rdata_reg <= rdata_next;
    end

    assign rdata     = rdata_reg;
    assign timer_irq = timer_irq_reg;
    assign misc_irq  = misc_irq_reg;
    assign irq       = irq_reg;
endmodule : ptpt_timer

// *** dv/ptpt_timer_asserts.sv ***
// Port-level checker for the precision-time timer
`timescale 1ns/1ps
module ptpt_timer_asserts
    import ptpt_pkg::*;
(
    input wire logic          clock,
    input wire logic          rst,
    input wire logic [AW-1:0] addr,
    input wire logic [TW-1:0] wdata,
    input wire logic          wr,
    input wire logic          rd,
    input wire logic [TW-1:0] rdata,
    input wire logic          tx_stamp_event,
    input wire logic          timer_irq,
    input wire logic          misc_irq,
    input wire logic          irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ************************************************************
    // Properties
    // ************************************************************
    property p_rd_idle; !rd |=> rdata == ZERO_WORD; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata nonzero without read");
    property p_unmapped; rd && addr == 8'hFC |=> rdata == ZERO_WORD; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_misc_sticky; $fell(misc_irq) |-> $past(wr) || $past(wr, 2); endproperty
    a_misc_sticky: assert property (p_misc_sticky) else $error("misc irq fell alone");
    property p_timer_sticky; $fell(timer_irq) |-> $past(wr) || $past(wr, 2); endproperty
    a_timer_sticky: assert property (p_timer_sticky) else $error("timer irq fell alone");
    property p_irq_sticky; $fell(irq) |-> $past(wr) || $past(wr, 2); endproperty
    a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell alone");
    // Unmasking a stale status bit is the only other way misc may rise
    property p_misc_cause;
        $rose(misc_irq) |-> $past(tx_stamp_event) || $past(tx_stamp_event, 2)
            || $past(tx_stamp_event, 3) || $past(wr) || $past(wr, 2);
    endproperty
    a_misc_cause: assert property (p_misc_cause) else $error("misc irq without cause");
    property p_misc_in_irq; misc_irq |-> irq; endproperty
    a_misc_in_irq: assert property (p_misc_in_irq) else $error("misc irq not in irq");
    property p_mask_off;
        wr && addr == OFS_IRQ_MASK && wdata == ZERO_WORD |-> ##2 !irq && !misc_irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq still high");
    c_misc: cover property ($rose(misc_irq));
    c_timer: cover property ($rose(timer_irq));
    c_irq: cover property ($rose(irq));
endmodule : ptpt_timer_asserts

bind ptpt_timer ptpt_timer_asserts i_chk (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .tx_stamp_event(tx_stamp_event), .timer_irq(timer_irq),
    .misc_irq(misc_irq), .irq(irq)
);

// *** dv/ptpt_timer_tb.sv ***
// Self-checking bench for the precision-time timer
`timescale 1ns/1ps
module ptpt_timer_tb
    import ptpt_pkg::*;
;
    localparam logic [AW-1:0] CH0_CSR = OFS_CH_BASE + OFS_CH_CSR;
    localparam logic [AW-1:0] CH0_CMP = OFS_CH_BASE + OFS_CH_CMP;
    localparam logic [AW-1:0] CH1_CSR = CH0_CSR + 8'h08;
    localparam logic [TW-1:0] CSR_ON  = 32'h0000_0040 | (TW'(MODE_OC_SW) << CSR_MODE_LSB);
    logic          clock;
    logic          rst;
    logic [AW-1:0] addr;
    logic [TW-1:0] wdata;
    logic          wr;
    logic          rd;
    logic [TW-1:0] rdata;
    logic [TW-1:0] v;
    logic          tx_stamp_event;
    logic          timer_irq;
    logic          misc_irq;
    logic          irq;
    int            fail_count;
    int            n_tests;

    ptpt_timer i_dut (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .tx_stamp_event(tx_stamp_event), .timer_irq(timer_irq),
        .misc_irq(misc_irq), .irq(irq)
    );

    // ************************************************************
    // Bus and check tasks
    // ************************************************************
    task automatic chk(input logic [TW-1:0] got, input logic [TW-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [AW-1:0] a, input logic [TW-1:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [AW-1:0] a);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg
    // Waits are bounded so a dead event source cannot hang the run
    task automatic wait_timer();
        for (int i = 0; i < 120 && timer_irq !== 1'b1; i++) @(posedge clock);
        #1 chk(TW'(timer_irq), 32'h0000_0001);
    endtask : wait_timer
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rd_reg(OFS_CTRL);
        chk(v, ZERO_WORD);
        rd_reg(OFS_PERIOD);
        chk(v, PERIOD_RST);
        rd_reg(8'hFC);
        chk(v, ZERO_WORD);
    endtask : t_reset
    task automatic t_wrap();
        wr_reg(OFS_INC, 32'h0000_0001);
        wr_reg(OFS_PERIOD, 32'h0000_0014);
        wr_reg(OFS_IRQ_MASK, 32'h0000_0002);
        wr_reg(OFS_CTRL, 32'h0000_0003);
        settle(60);
        chk(TW'(timer_irq), ZERO_WORD);
        chk(TW'(irq), 32'h0000_0001);
        rd_reg(OFS_IRQ_STAT);
        chk(v & 32'h0000_0002, 32'h0000_0002);
        rd_reg(OFS_TIME);
        chk(TW'(v <= 32'h0000_0014), 32'h0000_0001);
        wr_reg(OFS_CTRL, ZERO_WORD);
        wr_reg(OFS_IRQ_STAT, 32'h0000_0002);
        settle(3);
        chk(TW'(irq), ZERO_WORD);
    endtask : t_wrap
    task automatic t_tx();
        wr_reg(OFS_IRQ_MASK, 32'h0000_0001);
        tx_stamp_event <= 1'b1;
        @(posedge clock);
        tx_stamp_event <= 1'b0;
        settle(3);
        chk(TW'(misc_irq), 32'h0000_0001);
        chk(TW'(timer_irq), ZERO_WORD);
        wr_reg(OFS_IRQ_MASK, ZERO_WORD);
        settle(3);
        chk(TW'(misc_irq), ZERO_WORD);
        wr_reg(OFS_IRQ_STAT, 32'h0000_0001);
    endtask : t_tx
    task automatic t_chan();
        wr_reg(OFS_TIME, ZERO_WORD);
        wr_reg(OFS_INC, 32'h0000_0002);
        wr_reg(OFS_PERIOD, 32'h0000_0050);
        wr_reg(CH0_CMP, 32'h0000_004E);
        wr_reg(CH0_CSR, CSR_ON);
        wr_reg(CH0_CMP, 32'h0000_004E);
        wr_reg(CH1_CSR, 32'h0000_0040);
        wr_reg(OFS_IRQ_MASK, 32'h0000_0004);
        wr_reg(OFS_CTRL, 32'h0000_0003);
        wait_timer();
        rd_reg(CH0_CSR);
        chk(v & 32'h0000_0080, 32'h0000_0080);
        rd_reg(OFS_GSTAT);
        chk(v, 32'h0000_0001);
        rd_reg(OFS_IRQ_STAT);
        chk(v & 32'h0000_0004, 32'h0000_0004);
        wr_reg(CH0_CMP, 32'h0000_004E);
        wr_reg(CH0_CSR, CSR_ON | 32'h0000_0080);
        wr_reg(OFS_GSTAT, 32'h0000_0001);
        settle(3);
        chk(TW'(timer_irq), ZERO_WORD);
        rd_reg(CH0_CSR);
        chk(v & 32'h0000_0080, ZERO_WORD);
        wait_timer();
    endtask : t_chan

    task automatic results();
        $display("Checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (4000) @(posedge clock);
        fail_count++;
        results();
    end
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        tx_stamp_event = 1'b0;
        fail_count = 0;
        n_tests = 0;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_wrap();
        t_tx();
        t_chan();
        results();
    end
endmodule : ptpt_timer_tb
